/* File: dv/scirq_assertions.sv */
// Purpose: port checker of scirq_top
// Assumes: one clock, async active-high reset
// Notes: attached to every scirq_top by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
`include "scirq_cfg.svh"
module scirq_chk #(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [11:0] ser1_event,
   input wire logic [2:0] ser1_status,
   input wire logic [11:0] ser2_event,
   input wire logic [2:0] ser2_status,
   input wire logic [1:0] ser1_mode,
   input wire logic [1:0] ser2_mode,
   input wire logic ser1_irq,
   input wire logic ser2_irq,
   input wire logic irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   wire w1m = reg_wr && reg_addr == `SCIRQ_ADDR_S1_MODE;
   wire [1:0] wen = {reg_wr && reg_addr == `SCIRQ_ADDR_S2_EN, reg_wr && reg_addr == `SCIRQ_ADDR_S1_EN};
   sequence s_en_und;
      wen[0] && reg_wdata[4];
   endsequence
   sequence s_und_evt;
      ser1_event[1] && !reg_wr;
   endsequence
   a_irq_join: assert property (irq == (ser1_irq | ser2_irq))
      else $error("irq differs from unit requests");
   a_mode_load: assert property (w1m |=> ser1_mode == $past(reg_wdata[1:0]))
      else $error("mode field not loaded");
   a_mode_hold: assert property (!w1m |=> $stable(ser1_mode))
      else $error("mode field changed without write");
   a_no_uart2: assert property (ser2_mode != 2'h1)
      else $error("second unit in uart mode");
   a_und_irq: assert property (s_en_und ##1 s_und_evt |-> ##2 ser1_irq)
      else $error("underrun did not raise request");
   a_en1_drop: assert property (wen[0] && reg_wdata[14:0] == 15'h0 |=> ##1 !ser1_irq)
      else $error("request stayed with enables off");
   a_en2_drop: assert property (wen[1] && reg_wdata[14:0] == 15'h0 |=> ##1 !ser2_irq)
      else $error("second request stayed with enables off");
   a_clear_drop: assert property (reg_wr && reg_addr == `SCIRQ_ADDR_S1_PEND &&
      reg_wdata[14:0] == 15'h7fff && ser1_event == 12'h0 && ser1_status == 3'h0 |=> ##1 !ser1_irq)
      else $error("request stayed after clear");
endmodule
bind scirq_top scirq_chk #(
   .ADDR_W(ADDR_W),
   .DATA_W(DATA_W)
) u_chk (
   .core_clk(core_clk),
   .rst(rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .ser1_event(ser1_event),
   .ser1_status(ser1_status),
   .ser2_event(ser2_event),
   .ser2_status(ser2_status),
   .ser1_mode(ser1_mode),
   .ser2_mode(ser2_mode),
   .ser1_irq(ser1_irq),
   .ser2_irq(ser2_irq),
   .irq(irq)
);
`default_nettype wire

/* File: dv/scirq_host_model.sv */
// Purpose: top-level interrupt controller facing scirq_top
// Assumes: level request, one clock
// Notes: a request held high is taken once
`timescale 1ns/1ps
`default_nettype none
module scirq_host_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic irq,
   output logic [7:0] taken
);
   logic irq_reg;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_reg <= 1'b0;
         taken <= 8'h0;
      end
      else
      begin
         irq_reg <= irq;
         if (irq && !irq_reg)
            taken <= taken + 8'h1;
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of scirq_top
// Assumes: reads answer one cycle after the strobe
// Notes: reads queue their expectation, a monitor compares
`timescale 1ns/1ps
`default_nettype none
`include "scirq_cfg.svh"
module tb_top;
   logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
   logic ser1_irq, ser2_irq, irq;
   logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, seed = 32'h3e123089, e, d;
   logic [31:0] expq[$];
   logic [1:0][11:0] ev = 0;
   logic [1:0][2:0] st = 0;
   logic [1:0] ser1_mode, ser2_mode;
   logic [7:0] taken;
   int bad_count = 0, total_checks = 0;
   logic [31:0] ra[9] = '{`SCIRQ_ADDR_S1_PEND, `SCIRQ_ADDR_S2_PEND, `SCIRQ_ADDR_S1_EN, `SCIRQ_ADDR_S2_EN,
      `SCIRQ_ADDR_S1_TRIG, `SCIRQ_ADDR_S2_TRIG, `SCIRQ_ADDR_S1_MODE, `SCIRQ_ADDR_S2_MODE, 32'h4000a800};
   logic [31:0] rm[9] = '{32'h0, 32'h0, 32'h7fff, 32'h7fff, 32'h7, 32'h7, 32'h3, 32'h3, 32'h0};
   always #2.5 core_clk = ~core_clk;
   scirq_top u_dut (
      .core_clk(core_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .ser1_event(ev[0]),
      .ser1_status(st[0]),
      .ser2_event(ev[1]),
      .ser2_status(st[1]),
      .ser1_mode(ser1_mode),
      .ser2_mode(ser2_mode),
      .ser1_irq(ser1_irq),
      .ser2_irq(ser2_irq),
      .irq(irq)
   );
   scirq_host_model u_host (.core_clk(core_clk), .rst(rst), .irq(irq), .taken(taken));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // a read carries its expected word in d
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w)
         expq.push_back(d);
      @(posedge core_clk);
   endtask
   task automatic idle(input int n);
      reg_wr <= 0;
      reg_rd <= 0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic summarize();
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      if (rd_d)
         check(reg_rdata, expq.pop_front());
      else if (!rst)
         check(reg_rdata, 32'h0);
      rd_d <= reg_rd;
   end
   initial
   begin
      #50000;
      bad_count++;
      summarize();
   end
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      for (int k = 0; k < 9; k++)
      begin
         d = rnd();
         e = d & rm[k];
         if (k == 7 && e == 1)
            e = 0;
         acc(1, ra[k], d);
         acc(0, ra[k], e);
      end
      idle(1);
      rst <= 1;
      idle(2);
      rst <= 0;
      idle(1);
      for (int k = 0; k < 9; k++)
         acc(0, ra[k], 32'h0);
      $display("test registers done");
      for (int m = 0; m < 4; m++)
      begin
         acc(1, ra[6], m);
         acc(1, ra[7], m);
         acc(0, ra[6], m);
         acc(0, ra[7], m == 1 ? 0 : m);
         idle(1);
         check(ser1_mode, m);
         check(ser2_mode, m == 1 ? 0 : m);
      end
      $display("test modes done");
      acc(1, ra[2], 32'h7fff);
      acc(1, ra[3], 32'h7fff);
      for (int m = 0; m < 4; m++)
         for (int u = 0; u < 2; u++)
            for (int i = 0; i < 12; i++)
            begin
               acc(1, ra[6 + u], m);
               e = 32'h0;
               e[i + 3] = i > 9 ? u == 0 && m == 1 : i > 1 && i < 6 ? m == 3 : 1;
               ev[u] <= 12'h1 << i;
               idle(1);
               ev[u] <= 0;
               acc(0, ra[u], e);
               acc(1, ra[u], e);
               // the request launched at the read edge still shows here, the clear lands now
               check(u ? ser2_irq : ser1_irq, |e);
               acc(0, ra[u], 32'h0);
               idle(2);
               check(irq, 0);
            end
      $display("test events done");
      for (int u = 0; u < 2; u++)
         for (int b = 0; b < 3; b++)
            for (int lv = 0; lv < 2; lv++)
            begin
               acc(1, ra[4 + u], lv << b);
               st[u] <= 3'h1 << b;
               idle(3);
               acc(1, ra[u], 32'h1 << b);
               acc(0, ra[u], lv << b);
               acc(0, `SCIRQ_ADDR_RAW, 32'h1 << (b + 4 * u));
               st[u] <= 0;
               idle(1);
               acc(1, ra[u], 32'h7fff);
               acc(0, ra[u], 32'h0);
            end
      $display("test trigger modes done");
      // raise a second-unit request first so dropping its enables is seen to matter
      ev[1] <= 12'h2;
      idle(1);
      ev[1] <= 0;
      idle(1);
      acc(1, ra[3], 32'h0);
      check(ser2_irq, 1);
      acc(1, ra[2], 32'h10);
      ev[0] <= 12'h2;
      idle(1);
      ev[0] <= 0;
      acc(1, ra[2], 32'h0);
      idle(2);
      check(ser1_irq, 0);
      acc(1, ra[2], 32'h10);
      idle(2);
      check(ser1_irq, 1);
      acc(0, `SCIRQ_ADDR_SUMMARY, 32'h5);
      acc(1, ra[0], 32'h10);
      idle(2);
      check(ser1_irq, 0);
      check(|taken, 1);
      $display("test masking done");
      summarize();
   end
endmodule
`default_nettype wire

/* File: hdl/scirq_cfg.svh */
// Purpose: constants for the serial controller mode and interrupt block
// Assumes: 32-bit byte addresses on the register port
// Notes: offsets, field positions, reset values
`ifndef SCIRQ_CFG_SVH
`define SCIRQ_CFG_SVH

`define SCIRQ_ADDR_S1_PEND 32'h4000a808
`define SCIRQ_ADDR_S2_PEND 32'h4000a80c
`define SCIRQ_ADDR_S1_EN 32'h4000a848
`define SCIRQ_ADDR_S2_EN 32'h4000a84c
`define SCIRQ_ADDR_S1_TRIG 32'h4000a854
`define SCIRQ_ADDR_S2_TRIG 32'h4000a858
`define SCIRQ_ADDR_S2_MODE 32'h4000c054
`define SCIRQ_ADDR_S1_MODE 32'h4000c854
`define SCIRQ_ADDR_SUMMARY 32'h4000a8f0
`define SCIRQ_ADDR_RAW 32'h4000a8f4

`define SCIRQ_MODE_OFF 2'h0
`define SCIRQ_MODE_UART 2'h1
`define SCIRQ_MODE_SPI 2'h2
`define SCIRQ_MODE_TWI 2'h3

`define SCIRQ_BIT_PARERR 14
`define SCIRQ_BIT_FRMERR 13
`define SCIRQ_BIT_TXULDB 12
`define SCIRQ_BIT_RXULDA 9
`define SCIRQ_BIT_NACK 8
`define SCIRQ_BIT_RXFIN 5
`define SCIRQ_BIT_TXUND 4
`define SCIRQ_BIT_RXOVF 3
`define SCIRQ_BIT_TXIDLE 2
`define SCIRQ_BIT_TXFREE 1
`define SCIRQ_BIT_RXVAL 0

`define SCIRQ_RST_FLAGS 15'h0000
`define SCIRQ_RST_TRIG 3'h0
`define SCIRQ_RST_MODE 2'h0
`define SCIRQ_RST_WORD 32'h00000000

`endif

/* File: hdl/scirq_flags.sv */
// Purpose: pending flags of one serial controller
// Assumes: events are one-cycle pulses, status inputs are levels
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
`include "scirq_cfg.svh"
module scirq_flags #(
   parameter bit HAS_UART = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst,
   scirq_if.unit bus
);
   scirq_pkg::scirq_trig_t status_prev_reg;
   scirq_pkg::scirq_flags_t pend_reg;
   scirq_pkg::scirq_flags_t set_next;
   logic uart_on;
   logic twi_on;

   // uart errors only exist on a unit built with the uart
   assign uart_on = HAS_UART && (bus.mode == `SCIRQ_MODE_UART);
   assign twi_on = (bus.mode == `SCIRQ_MODE_TWI);

   always_comb
   begin
      set_next = `SCIRQ_RST_FLAGS;
      set_next[`SCIRQ_BIT_PARERR:`SCIRQ_BIT_FRMERR] = uart_on ? bus.events[11:10] : 2'h0;
      set_next[`SCIRQ_BIT_TXULDB:`SCIRQ_BIT_RXULDA] = bus.events[9:6];
      set_next[`SCIRQ_BIT_NACK:`SCIRQ_BIT_RXFIN] = twi_on ? bus.events[5:2] : 4'h0;
      set_next[`SCIRQ_BIT_TXUND:`SCIRQ_BIT_RXOVF] = bus.events[1:0];
      for (int i = 0; i < 3; i++)
      begin
         // level: set while high, edge: set on the rising transition
         set_next[i] = bus.trig[i] ? bus.status[i] : (bus.status[i] & ~status_prev_reg[i]);
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         status_prev_reg <= `SCIRQ_RST_TRIG;
      else
         status_prev_reg <= bus.status;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         pend_reg <= `SCIRQ_RST_FLAGS;
      else
         pend_reg <= (pend_reg & ~bus.clear) | set_next;
   end

   assign bus.pend = pend_reg;
endmodule
`default_nettype wire

/* File: hdl/scirq_if.sv */
// Purpose: carrier between the register block and one flag unit
// Assumes: one clock domain
// Notes: clear is a one-cycle write-one mask
`timescale 1ns/1ps
`default_nettype none
interface scirq_if;
   scirq_pkg::scirq_events_t events;
   scirq_pkg::scirq_trig_t status;
   scirq_pkg::scirq_trig_t trig;
   scirq_pkg::scirq_mode_t mode;
   scirq_pkg::scirq_flags_t clear;
   scirq_pkg::scirq_flags_t pend;
   modport regs (output events, output status, output trig, output mode, output clear, input pend);
   modport unit (input events, input status, input trig, input mode, input clear, output pend);
endinterface
`default_nettype wire

/* File: hdl/scirq_pkg.sv */
// Purpose: shared types of the serial controller interrupt block
// Assumes: nothing beyond the cfg header
// Notes: widths only, constants live in scirq_cfg.svh
package scirq_pkg;
   typedef logic [14:0] scirq_flags_t;
   typedef logic [11:0] scirq_events_t;
   typedef logic [2:0] scirq_trig_t;
   typedef logic [1:0] scirq_mode_t;
endpackage

/* File: hdl/scirq_top.sv */
// Purpose: mode select and second-level interrupts of two serial controllers
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes: irq outputs follow a pending flag by one cycle
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "scirq_cfg.svh"
module scirq_top #(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [11:0] ser1_event,
   input wire logic [2:0] ser1_status,
   input wire logic [11:0] ser2_event,
   input wire logic [2:0] ser2_status,
   output logic [1:0] ser1_mode,
   output logic [1:0] ser2_mode,
   output logic ser1_irq,
   output logic ser2_irq,
   output logic irq
);
   scirq_if s1_bus ();
   scirq_if s2_bus ();

   scirq_pkg::scirq_flags_t s1_en_reg;
   scirq_pkg::scirq_flags_t s2_en_reg;
   scirq_pkg::scirq_trig_t s1_trig_reg;
   scirq_pkg::scirq_trig_t s2_trig_reg;
   scirq_pkg::scirq_mode_t s1_mode_reg;
   scirq_pkg::scirq_mode_t s2_mode_reg;
   logic s1_irq_reg;
   logic s2_irq_reg;
   logic irq_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] off);
      hit = (a == off[ADDR_W-1:0]);
   endfunction

   function automatic logic [DATA_W-1:0] widen(input logic [14:0] v);
      logic [DATA_W-1:0] w;
      w = '0;
      w[14:0] = v;
      widen = w;
   endfunction

   function automatic logic wants(input scirq_pkg::scirq_flags_t p, input scirq_pkg::scirq_flags_t e);
      wants = |(p & e);
   endfunction

   // unit wiring
   assign s1_bus.events = ser1_event;
   assign s1_bus.status = ser1_status;
   assign s1_bus.trig = s1_trig_reg;
   assign s1_bus.mode = s1_mode_reg;
   assign s1_bus.clear = (reg_wr && hit(reg_addr, `SCIRQ_ADDR_S1_PEND)) ? reg_wdata[14:0] : `SCIRQ_RST_FLAGS;
   assign s2_bus.events = ser2_event;
   assign s2_bus.status = ser2_status;
   assign s2_bus.trig = s2_trig_reg;
   assign s2_bus.mode = s2_mode_reg;
   assign s2_bus.clear = (reg_wr && hit(reg_addr, `SCIRQ_ADDR_S2_PEND)) ? reg_wdata[14:0] : `SCIRQ_RST_FLAGS;

   scirq_flags #(
      .HAS_UART(1'b1)
   ) u_s1 (
      .core_clk(core_clk),
      .rst(rst),
      .bus(s1_bus.unit)
   );

   // second unit has no uart, so its error bits never set
   scirq_flags #(
      .HAS_UART(1'b0)
   ) u_s2 (
      .core_clk(core_clk),
      .rst(rst),
      .bus(s2_bus.unit)
   );

   // enable registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_en_reg <= `SCIRQ_RST_FLAGS;
         s2_en_reg <= `SCIRQ_RST_FLAGS;
      end
      else if (reg_wr)
      begin
         if (hit(reg_addr, `SCIRQ_ADDR_S1_EN))
            s1_en_reg <= reg_wdata[14:0];
         if (hit(reg_addr, `SCIRQ_ADDR_S2_EN))
            s2_en_reg <= reg_wdata[14:0];
      end
   end

   // trigger mode registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_trig_reg <= `SCIRQ_RST_TRIG;
         s2_trig_reg <= `SCIRQ_RST_TRIG;
      end
      else if (reg_wr)
      begin
         if (hit(reg_addr, `SCIRQ_ADDR_S1_TRIG))
            s1_trig_reg <= reg_wdata[2:0];
         if (hit(reg_addr, `SCIRQ_ADDR_S2_TRIG))
            s2_trig_reg <= reg_wdata[2:0];
      end
   end

   // mode registers; a uart request to the second unit is dropped and the old mode kept,
   // so a misconfigured driver cannot start an engine that is not there
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_mode_reg <= `SCIRQ_RST_MODE;
         s2_mode_reg <= `SCIRQ_RST_MODE;
      end
      else if (reg_wr)
      begin
         if (hit(reg_addr, `SCIRQ_ADDR_S1_MODE))
            s1_mode_reg <= reg_wdata[1:0];
         if (hit(reg_addr, `SCIRQ_ADDR_S2_MODE) && (reg_wdata[1:0] != `SCIRQ_MODE_UART))
            s2_mode_reg <= reg_wdata[1:0];
      end
   end

   // interrupt requests, registered so every output leaves a flop
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_irq_reg <= 1'b0;
         s2_irq_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         s1_irq_reg <= wants(s1_bus.pend, s1_en_reg);
         s2_irq_reg <= wants(s2_bus.pend, s2_en_reg);
         irq_reg <= wants(s1_bus.pend, s1_en_reg) | wants(s2_bus.pend, s2_en_reg);
      end
   end

   // read decode; unmapped addresses read zero
   always_comb
   begin
      rdata_next = `SCIRQ_RST_WORD;
      if (hit(reg_addr, `SCIRQ_ADDR_S1_PEND))
         rdata_next = widen(s1_bus.pend);
      else if (hit(reg_addr, `SCIRQ_ADDR_S2_PEND))
         rdata_next = widen(s2_bus.pend);
      else if (hit(reg_addr, `SCIRQ_ADDR_S1_EN))
         rdata_next = widen(s1_en_reg);
      else if (hit(reg_addr, `SCIRQ_ADDR_S2_EN))
         rdata_next = widen(s2_en_reg);
      else if (hit(reg_addr, `SCIRQ_ADDR_S1_TRIG))
         rdata_next = widen({12'h000, s1_trig_reg});
      else if (hit(reg_addr, `SCIRQ_ADDR_S2_TRIG))
         rdata_next = widen({12'h000, s2_trig_reg});
      else if (hit(reg_addr, `SCIRQ_ADDR_S1_MODE))
         rdata_next = widen({13'h0000, s1_mode_reg});
      else if (hit(reg_addr, `SCIRQ_ADDR_S2_MODE))
         rdata_next = widen({13'h0000, s2_mode_reg});
      else if (hit(reg_addr, `SCIRQ_ADDR_SUMMARY))
         rdata_next = widen({12'h000, irq_reg, s2_irq_reg, s1_irq_reg});
      else if (hit(reg_addr, `SCIRQ_ADDR_RAW))
         rdata_next = widen({7'h00, 1'b0, ser2_status, 1'b0, ser1_status});
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rdata_reg <= `SCIRQ_RST_WORD;
      else if (reg_rd)
         rdata_reg <= rdata_next;
      else
         rdata_reg <= `SCIRQ_RST_WORD;
   end

   assign reg_rdata = rdata_reg;
   assign ser1_mode = s1_mode_reg;
   assign ser2_mode = s2_mode_reg;
   assign ser1_irq = s1_irq_reg;
   assign ser2_irq = s2_irq_reg;
   assign irq = irq_reg;
endmodule
`default_nettype wire
